/* asfc_pkg.sv */
package asfc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 4;
  localparam int CLK_PERIOD_NS = 10;
  // timing figures of the fastest grade, in ns
  localparam int ADDR_ACCESS_NS = 20;
  localparam int GATE_ACCESS_NS = 10;
  localparam int READ_HOLD_NS = 5;
  localparam int STROBE_RELEASE_NS = 8;
  localparam int SEL_TO_WRITE_END_NS = 18;
  localparam int STROBE_TO_WRITE_END_NS = 16;
  localparam int DATA_SETUP_NS = 12;
  localparam int SEL_TO_CLEAR_END_NS = 40;
  localparam int WIPE_TO_CLEAR_END_NS = 38;
  localparam int CNT_W = 4;
  // least times round up
  localparam int ACCESS_CYC = (ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_CYC = (STROBE_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC = (SEL_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLEAR_CYC = (SEL_TO_CLEAR_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] ACCESS_CNT = CNT_W'(ACCESS_CYC);
  localparam logic [CNT_W-1:0] RELEASE_CNT = CNT_W'(RELEASE_CYC);
  localparam logic [CNT_W-1:0] WRITE_CNT = CNT_W'(WRITE_CYC);
  localparam logic [CNT_W-1:0] CLEAR_CNT = CNT_W'(CLEAR_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

  typedef enum logic [1:0] {
    ASFC_OP_READ,
    ASFC_OP_WRITE,
    ASFC_OP_CLEAR
  } asfc_op_e;

  typedef struct packed {
    asfc_op_e            op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } asfc_req_s;

  typedef struct packed {
    logic                chipSelectN;
    logic                outputGateN;
    logic                writeStrobeN;
    logic                wipeAllN;
    logic [ADDR_W-1:0]   wordSelectLines;
  } asfc_pins_s;
endpackage : asfc_pkg

/* asfc_host.sv */
`timescale 1ns/1ns
// Contract
// R1 - chip select high deselects device; bus floats, inputs ignored, standby.
// R2 - device powers down automatically while chip select is high.
// R3 - select low, strobe high, wipe high gives ripple-through read.
// R4 - twelve address lines pick one of 4096 nibbles.
// R5 - device drives data only while output gate low during read.
// R6 - read data valid within address access delay, 20 ns fastest.
// R7 - read data valid within output gate access delay, 10 ns.
// R8 - data may be indeterminate before access delay; then correct.
// R9 - old read data held at least 5 ns after address change.
// R10 - read cycle time equals address access time.
// R11 - select and strobe both low means write of data lines.
// R12 - write starts at later falling edge, ends at earlier rise.
// R13 - host changes address only while select or strobe high.
// R14 - host holds address stable through whole write cycle.
// R15 - host holds select low 18 ns, strobe low 16 ns.
// R16 - device releases bus after strobe falls; host waits before driving. Host drives data with gate high a cycle before strobe falls.
// R17 - flash clear zeroes all 16,384 bits at once.
// R18 - clear begins when select and wipe are both low.
// R19 - clear ends when select or wipe rises; wipe alone ignored.
// R20 - during clear bus driven only with gate low, strobe high.
// R21 - host holds select low 40 ns, wipe low 38 ns for clear.
// R22 - clear may sit in read or write; write timing after wipe rises.
// R23 - contents undefined after power-up until written or cleared.
module asfc_host (
  input  wire logic                        ref_clk,        // 100 MHz clock
  input  wire logic                        rst,            // async reset, active high
  input  wire logic                        reqValid,       // request offered
  input  wire asfc_pkg::asfc_req_s         reqData,        // operation, address, write data
  output logic                             reqReady,       // idle, request taken
  output logic                             respValid,      // one-cycle done pulse
  output logic [asfc_pkg::DATA_W-1:0]      respData,       // read nibble
  output asfc_pkg::asfc_pins_s             pins,           // device control pins
  output logic [asfc_pkg::DATA_W-1:0]      dataOut,        // data bus drive value
  output logic                             dataOe,         // data bus drive enable
  input  wire logic [asfc_pkg::DATA_W-1:0] dataIn          // data bus level
);
  // returning bus passes two flops before any logic reads it
  localparam int SYNC_DEPTH = 2;
  // read wait covers the access time plus the synchroniser delay
  localparam int READ_WAIT_CYC = asfc_pkg::ACCESS_CYC + SYNC_DEPTH;
  localparam logic [asfc_pkg::CNT_W-1:0] READ_WAIT = READ_WAIT_CYC[asfc_pkg::CNT_W-1:0];
  // every control pin inactive, address parked at zero
  localparam asfc_pkg::asfc_pins_s PINS_IDLE = '{
    chipSelectN:     1'h1,
    outputGateN:     1'h1,
    writeStrobeN:    1'h1,
    wipeAllN:        1'h1,
    wordSelectLines: {asfc_pkg::ADDR_W{1'h0}}
  };

  typedef enum logic [2:0] {
    ASFC_IDLE,
    ASFC_READ,
    ASFC_WSET,
    ASFC_WRITE,
    ASFC_WEND,
    ASFC_CLEAR,
    ASFC_DONE
  } asfc_state_e;

  asfc_state_e                 state_q;
  asfc_state_e                 state_d;
  logic [asfc_pkg::CNT_W-1:0]  cnt_q;
  logic [asfc_pkg::CNT_W-1:0]  cnt_d;
  asfc_pkg::asfc_pins_s        pins_q;
  asfc_pkg::asfc_pins_s        pins_d;
  logic                        reqReady_q;
  logic                        reqReady_d;
  logic                        respValid_q;
  logic                        respValid_d;
  logic [asfc_pkg::DATA_W-1:0] respData_q;
  logic [asfc_pkg::DATA_W-1:0] respData_d;
  logic [asfc_pkg::DATA_W-1:0] dataOut_q;
  logic [asfc_pkg::DATA_W-1:0] dataOut_d;
  logic                        dataOe_q;
  logic                        dataOe_d;
  wire  [asfc_pkg::DATA_W-1:0] dataSync;

  // two-flop synchroniser per data bit
  genvar bitIdx;
  generate
    for (bitIdx = 0; bitIdx < asfc_pkg::DATA_W; bitIdx++) begin : g_sync
      logic meta_q;
      logic stable_q;
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          meta_q   <= 1'h0;
          stable_q <= 1'h0;
        end else begin
          meta_q   <= dataIn[bitIdx];
          stable_q <= meta_q;
        end
      end
      assign dataSync[bitIdx] = stable_q;
    end
  endgenerate

  // request decode
  wire reqTake   = reqValid && reqReady_q;
  wire opRead    = (reqData.op == asfc_pkg::ASFC_OP_READ);
  wire opWrite   = (reqData.op == asfc_pkg::ASFC_OP_WRITE);
  wire opClear   = (reqData.op == asfc_pkg::ASFC_OP_CLEAR);
  wire takeRead  = reqTake && opRead;
  wire takeWrite = reqTake && opWrite;
  wire takeClear = reqTake && opClear;
  wire takeOther = reqTake && !opRead && !opWrite && !opClear;

  // counter decode
  wire                       cntZero = (cnt_q == asfc_pkg::CNT_ZERO);
  wire                       cntLast = (cnt_q == asfc_pkg::CNT_ONE);
  wire [asfc_pkg::CNT_W-1:0] cntDown = cnt_q - asfc_pkg::CNT_ONE;

  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    pins_d      = pins_q;
    reqReady_d  = 1'h0;
    respValid_d = 1'h0;
    respData_d  = respData_q;
    dataOut_d   = dataOut_q;
    dataOe_d    = dataOe_q;
    unique case (state_q)
      ASFC_IDLE: begin
        reqReady_d = !reqTake;
        if (takeRead) begin
          // gate low at once: data ripples out after the access time
          pins_d.wordSelectLines = reqData.addr;
          pins_d.chipSelectN     = 1'h0;
          pins_d.outputGateN     = 1'h0;
          pins_d.writeStrobeN    = 1'h1;
          pins_d.wipeAllN        = 1'h1;
          cnt_d                  = READ_WAIT;
          state_d                = ASFC_READ;
        end else if (takeWrite) begin
          // gate stays high so the device never drives against us
          pins_d.wordSelectLines = reqData.addr; // [R13]
          pins_d.chipSelectN     = 1'h0;
          pins_d.outputGateN     = 1'h1;
          pins_d.writeStrobeN    = 1'h1;
          pins_d.wipeAllN        = 1'h1;
          dataOut_d              = reqData.wdata;
          dataOe_d               = 1'h1;
          state_d                = ASFC_WSET;
        end else if (takeClear) begin
          pins_d.chipSelectN  = 1'h0; // [R21]
          pins_d.outputGateN  = 1'h1;
          pins_d.writeStrobeN = 1'h1;
          pins_d.wipeAllN     = 1'h0;
          cnt_d               = asfc_pkg::CLEAR_CNT;
          state_d             = ASFC_CLEAR;
        end else if (takeOther) begin
          // unknown operation code: answer without touching the pins
          respValid_d = 1'h1;
          state_d     = ASFC_DONE;
        end
      end
      ASFC_READ: begin
        if (cntZero) begin
          respData_d         = dataSync;
          pins_d.chipSelectN = 1'h1;
          pins_d.outputGateN = 1'h1;
          respValid_d        = 1'h1;
          state_d            = ASFC_DONE;
        end else begin
          cnt_d = cntDown;
        end
      end
      ASFC_WSET: begin
        // data already stands a full cycle before the strobe falls
        pins_d.writeStrobeN = 1'h0;
        cnt_d               = asfc_pkg::WRITE_CNT;
        state_d             = ASFC_WRITE;
      end
      ASFC_WRITE: begin
        if (cntLast) begin
          pins_d.writeStrobeN = 1'h1; // [R15]
          state_d             = ASFC_WEND;
        end else begin
          cnt_d = cntDown;
        end
      end
      ASFC_WEND: begin
        // address and data held one cycle past the strobe rise
        pins_d.chipSelectN = 1'h1; // [R14]
        dataOe_d           = 1'h0;
        respValid_d        = 1'h1;
        state_d            = ASFC_DONE;
      end
      ASFC_CLEAR: begin
        if (cntLast) begin
          // clear stands alone, so any later write starts with fresh timing
          pins_d.chipSelectN = 1'h1; // [R21] [R22]
          pins_d.wipeAllN    = 1'h1;
          respValid_d        = 1'h1;
          state_d            = ASFC_DONE;
        end else begin
          cnt_d = cntDown;
        end
      end
      ASFC_DONE: begin
        reqReady_d = 1'h1;
        state_d    = ASFC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q     <= ASFC_IDLE;
      cnt_q       <= asfc_pkg::CNT_ZERO;
      pins_q      <= PINS_IDLE;
      reqReady_q  <= 1'h1;
      respValid_q <= 1'h0;
      respData_q  <= {asfc_pkg::DATA_W{1'h0}};
      dataOut_q   <= {asfc_pkg::DATA_W{1'h0}};
      dataOe_q    <= 1'h0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      pins_q      <= pins_d;
      reqReady_q  <= reqReady_d;
      respValid_q <= respValid_d;
      respData_q  <= respData_d;
      dataOut_q   <= dataOut_d;
      dataOe_q    <= dataOe_d;
    end
  end

  // outputs straight from flops
  assign reqReady  = reqReady_q;
  assign respValid = respValid_q;
  assign respData  = respData_q;
  assign pins      = pins_q;
  assign dataOut   = dataOut_q;
  assign dataOe    = dataOe_q;
endmodule : asfc_host

/* asfc_sram_model.sv */
`timescale 1ns/1ns
module asfc_sram_model (
  input  wire asfc_pkg::asfc_pins_s p,  // control pins
  input  wire logic [3:0]           d,  // bus level
  output logic                      oe, // memory drives the bus
  output logic [3:0]                q   // memory drive value
);
  logic [3:0] m [4096]; // contents start unknown
  wire s = !p.chipSelectN;
  wire rd = s && p.writeStrobeN;
  assign oe = rd && !p.outputGateN;
  assign #19 q = m[p.wordSelectLines];
  always @* if (s && !p.writeStrobeN && p.wipeAllN) m[p.wordSelectLines] = d;
  always @* if (s && !p.wipeAllN) foreach (m[i]) m[i] = 4'h0;
endmodule : asfc_sram_model

/* asfc_host_sva.sv */
`timescale 1ns/1ns
module asfc_host_sva (
  input wire logic                 ref_clk, // controller clock
  input wire logic                 rst,     // async reset, active high
  input wire asfc_pkg::asfc_pins_s pins,    // device control pins
  input wire logic                 dataOe   // controller drives the bus
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  strobe_low_a: assert property ($fell(pins.writeStrobeN) |-> !pins.writeStrobeN [*2])
    else $error("write strobe low time too short");
  select_write_a: assert property ($fell(pins.writeStrobeN) |-> !pins.chipSelectN [*3])
    else $error("select low time too short for write");
  addr_write_stable_a: assert property ((!pins.chipSelectN && !pins.writeStrobeN) |-> $stable(pins.wordSelectLines))
    else $error("address moved during write");
  addr_write_hold_a: assert property (($rose(pins.writeStrobeN) && !pins.chipSelectN) |-> $stable(pins.wordSelectLines))
    else $error("address moved at write end");
  wipe_low_a: assert property ($fell(pins.wipeAllN) |-> !pins.wipeAllN [*4])
    else $error("wipe low time too short");
  select_clear_a: assert property ($fell(pins.wipeAllN) |-> !pins.chipSelectN [*4])
    else $error("select low time too short for clear");
  bus_contention_a: assert property ((!pins.chipSelectN && !pins.outputGateN) |-> !dataOe)
    else $error("bus driven while memory outputs enabled");
  write_data_a: assert property ($fell(pins.writeStrobeN) |-> dataOe)
    else $error("write strobe without data driven");
  clear_alone_a: assert property (!pins.wipeAllN |-> pins.writeStrobeN)
    else $error("clear overlaps write strobe");
endmodule : asfc_host_sva
bind asfc_host asfc_host_sva asfc_host_sva_inst (
  .ref_clk (ref_clk),
  .rst     (rst),
  .pins    (pins),
  .dataOe  (dataOe)
);

/* tb_async_sram_4kx4_flash_clear.sv */
`timescale 1ns/1ns
module tb_async_sram_4kx4_flash_clear;
  localparam int TIMEOUT_CYC = 1000; // fourteen operations of about eight cycles each, with wide slack
  logic                 ref_clk    = 1'h0;
  logic                 rst        = 1'h1;
  logic                 reqValid   = 1'h0;
  asfc_pkg::asfc_req_s  reqData    = '0;
  logic                 reqReady;
  logic                 respValid;
  logic [3:0]           respData;
  asfc_pkg::asfc_pins_s pins;
  logic [3:0]           dataOut;
  logic                 dataOe;
  logic                 oe;
  logic [3:0]           q;
  int                   mismatches = 0;
  int                   nChecks    = 0;
  // released bus shows the inverse of the last value driven
  wire [3:0] dataIn = dataOe ? dataOut : (oe ? q : ~dataOut);

  asfc_host asfc_host_inst (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .reqValid  (reqValid),
    .reqData   (reqData),
    .reqReady  (reqReady),
    .respValid (respValid),
    .respData  (respData),
    .pins      (pins),
    .dataOut   (dataOut),
    .dataOe    (dataOe),
    .dataIn    (dataIn)
  );
  asfc_sram_model asfc_sram_model_inst (
    .p  (pins),
    .d  (dataIn),
    .oe (oe),
    .q  (q)
  );

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic end_of_test;
    if (mismatches == 0 && nChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // request held until taken at a ready edge, then wait for the done pulse
  task automatic op(input asfc_pkg::asfc_op_e o, input logic [11:0] a, input logic [3:0] w);
    @(posedge ref_clk);
    #1;
    reqValid = 1'h1;
    reqData  = '{op: o, addr: a, wdata: w};
    do @(posedge ref_clk); while (reqReady !== 1'h1);
    #1;
    reqValid = 1'h0;
    do begin
      @(posedge ref_clk);
      #1;
    end while (respValid !== 1'h1);
  endtask : op

  task automatic after_op;
    check("chipSelectN", pins.chipSelectN, 16'h0001);
    check("wipeAllN", pins.wipeAllN, 16'h0001);
    check("dataOe", dataOe, 16'h0000);
    @(posedge ref_clk);
    #1;
    check("respValid", respValid, 16'h0000);
  endtask : after_op

  task automatic write_word(input logic [11:0] a, input logic [3:0] w);
    op(asfc_pkg::ASFC_OP_WRITE, a, w);
    after_op();
  endtask : write_word

  task automatic read_expect(input logic [11:0] a, input logic [3:0] e);
    op(asfc_pkg::ASFC_OP_READ, a, 4'h0);
    check("respData", respData, {12'h000, e});
    after_op();
  endtask : read_expect

  task automatic t_write_read;
    write_word(12'hFFF, 4'hA);
    write_word(12'h000, 4'h5);
    write_word(12'h7FF, 4'h3);
    read_expect(12'hFFF, 4'hA);
    read_expect(12'h000, 4'h5);
    read_expect(12'h7FF, 4'h3);
  endtask : t_write_read

  task automatic t_clear;
    op(asfc_pkg::ASFC_OP_CLEAR, 12'h000, 4'h0);
    after_op();
    read_expect(12'h000, 4'h0);
    read_expect(12'hFFF, 4'h0);
    read_expect(12'h7FF, 4'h0);
  endtask : t_clear

  task automatic t_write_after_clear;
    write_word(12'h123, 4'h9);
    read_expect(12'h123, 4'h9);
    read_expect(12'h124, 4'h0);
  endtask : t_write_after_clear

  task automatic t_mid_reset;
    @(posedge ref_clk);
    #1;
    rst = 1'h1;
    @(posedge ref_clk);
    #1;
    check("chipSelectN", pins.chipSelectN, 16'h0001);
    check("reqReady", reqReady, 16'h0001);
    check("respValid", respValid, 16'h0000);
    check("dataOe", dataOe, 16'h0000);
    repeat (2) @(posedge ref_clk);
    #1;
    rst = 1'h0;
    read_expect(12'h123, 4'h9);
  endtask : t_mid_reset

  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    rst = 1'h0;
    t_write_read();
    t_clear();
    t_write_after_clear();
    t_mid_reset();
    end_of_test();
  end

  initial begin
    repeat (TIMEOUT_CYC) @(posedge ref_clk);
    mismatches++;
    end_of_test();
  end
endmodule : tb_async_sram_4kx4_flash_clear
